/* File: design/eth_phy_pkg.sv */
package eth_phy_pkg;
  // Register byte offsets on the Wishbone slave
  localparam logic [7:0] REG_MGMT_ADDR = 8'h00;
  localparam logic [7:0] REG_MGMT_DATA = 8'h04;
  localparam logic [7:0] REG_LINK_CFG = 8'h08;
  localparam logic [7:0] REG_LINK_STAT = 8'h0C;
  // Management address register fields
  localparam int MA_BUSY = 0;
  localparam int MA_WRITE = 1;
  localparam int MA_RANGE = 2;
  localparam int MA_REG = 6;
  localparam int MA_PHY = 11;
  // Link configuration and status fields
  localparam int LC_RMII = 0;
  localparam int LC_FDX = 1;
  localparam int LS_FALSE_CAR = 0;
  localparam int LS_RX_ERR = 1;
  localparam int LS_COLL = 2;
  localparam int LS_CRS = 3;
  // Values after reset
  localparam logic [15:0] MGMT_ADDR_RST = 16'h0000;
  localparam logic [15:0] MGMT_DATA_RST = 16'h0000;
  localparam logic [1:0] LINK_CFG_RST = 2'h0;
  // Management clock divisors per range code
  localparam logic [6:0] MDC_DIV_000 = 7'd42;
  localparam logic [6:0] MDC_DIV_001 = 7'd62;
  localparam logic [6:0] MDC_DIV_010 = 7'd16;
  localparam logic [6:0] MDC_DIV_011 = 7'd26;
  localparam logic [6:0] MDC_DIV_100 = 7'd102;
  // Timing floor of the management clock
  localparam int CLK_PERIOD_NS = 4;
  localparam int MDC_MIN_PHASE_NS = 160;
  localparam int MDC_MIN_PERIOD_NS = 400;
  localparam int MIN_PHASE_CYC = (MDC_MIN_PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MIN_PERIOD_CYC = (MDC_MIN_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MIN_HALF_CYC = (MIN_PHASE_CYC > (MIN_PERIOD_CYC + 1) / 2) ?
                                MIN_PHASE_CYC : (MIN_PERIOD_CYC + 1) / 2;
  localparam logic [6:0] MDC_HALF_MIN = 7'(MIN_HALF_CYC);
  // Management frame layout, bit 0 is the first on the wire
  localparam logic [5:0] FRAME_LAST = 6'd63;
  localparam logic [5:0] PRE_BITS = 6'd32;
  localparam logic [5:0] TA_POS = 6'd46;
  localparam logic [5:0] DATA_POS = 6'd48;
  localparam logic [1:0] START_PAT = 2'h1;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] TA_WRITE = 2'h2;
  // Receive classification codes
  localparam logic [2:0] RXC_IDLE = 3'h0;
  localparam logic [2:0] RXC_DATA = 3'h1;
  localparam logic [2:0] RXC_DATA_ERR = 3'h2;
  localparam logic [2:0] RXC_FALSE_CAR = 3'h3;
  localparam logic [2:0] RXC_RESERVED = 3'h4;
  typedef enum logic [2:0] {
    MS_IDLE = 3'b001,
    MS_LOW = 3'b010,
    MS_HIGH = 3'b100
  } mdc_state_e;
endpackage : eth_phy_pkg

/* File: design/mgmt_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface mgmt_if;
  logic start;
  logic wr;
  logic [2:0] range;
  logic [4:0] phy;
  logic [4:0] reg_a;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic done;
  modport ctrl (output start, wr, range, phy, reg_a, wdata, input rdata, done);
  modport engine (input start, wr, range, phy, reg_a, wdata, output rdata, done);
endinterface : mgmt_if
`default_nettype wire

/* File: design/station_mgmt_master.sv */
`timescale 1ns/1ps
`default_nettype none
module station_mgmt_master
  import eth_phy_pkg::*;
(
  input wire logic clk_i,       // System clock
  input wire logic rst_i,       // Synchronous reset
  input wire logic ce_i,        // Clock enable
  mgmt_if.engine cmd,           // Command from register block
  input wire logic mdio_in_i,   // Synchronised data line
  output logic mdc_o,           // Management clock
  output logic mdio_o,          // Data line drive value
  output logic mdio_oe_o        // Data line drive enable
);
  mdc_state_e state_q;
  logic [6:0] cnt_q;
  logic [5:0] bit_q;
  logic [63:0] shift_q;
  logic wr_q;
  logic [15:0] rdata_q;
  logic done_q;
  logic [6:0] div_w;
  logic [6:0] half_w;
  logic last_w;
  logic drive_next_w;

  // Divisor from the range code; reserved codes fall back to the slowest
  assign div_w = (cmd.range == 3'h0) ? MDC_DIV_000 :  // R12
                 (cmd.range == 3'h1) ? MDC_DIV_001 :
                 (cmd.range == 3'h2) ? MDC_DIV_010 :
                 (cmd.range == 3'h3) ? MDC_DIV_011 : MDC_DIV_100;
  // Clamp keeps fast codes legal at this clock rate
  assign half_w = ((div_w >> 1) < MDC_HALF_MIN) ? MDC_HALF_MIN : (div_w >> 1);  // R3
  assign last_w = (bit_q == FRAME_LAST);
  // Reads let go of the line from the turnaround onward
  assign drive_next_w = wr_q || ((bit_q + 6'd1) < TA_POS);  // R8 R9
  assign cmd.rdata = rdata_q;
  assign cmd.done = done_q;

  // One frame at a time: preamble, start, op, addresses, turnaround, data
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= MS_IDLE;
      cnt_q <= 7'h00;
      bit_q <= 6'h00;
      shift_q <= 64'h0;
      wr_q <= 1'b0;
      rdata_q <= 16'h0000;
      done_q <= 1'b0;
      mdc_o <= 1'b0;
      mdio_o <= 1'b0;
      mdio_oe_o <= 1'b0;
    end else if (ce_i) begin
      done_q <= 1'b0;
      case (state_q)
        MS_IDLE: begin
          mdc_o <= 1'b0;  // R2
          mdio_oe_o <= 1'b0;  // R11
          if (cmd.start) begin
            shift_q <= {32'hFFFFFFFF, START_PAT, cmd.wr ? OP_WRITE : OP_READ,  // R4 R5 R21
                        cmd.phy, cmd.reg_a, TA_WRITE, cmd.wdata};  // R1 R6 R7 R10
            wr_q <= cmd.wr;
            bit_q <= 6'h00;
            cnt_q <= half_w - 7'd1;
            mdio_o <= 1'b1;
            mdio_oe_o <= 1'b1;
            state_q <= MS_LOW;
          end
        end
        MS_LOW: begin
          if (cnt_q == 7'h00) begin
            mdc_o <= 1'b1;
            cnt_q <= half_w - 7'd1;
            state_q <= MS_HIGH;
            if (!wr_q && bit_q >= DATA_POS) begin
              rdata_q <= {rdata_q[14:0], mdio_in_i};  // R22 R10
            end
          end else begin
            cnt_q <= cnt_q - 7'd1;
          end
        end
        MS_HIGH: begin
          if (cnt_q != 7'h00) begin
            cnt_q <= cnt_q - 7'd1;
          end else if (last_w) begin
            mdc_o <= 1'b0;
            mdio_oe_o <= 1'b0;  // R11
            done_q <= 1'b1;
            state_q <= MS_IDLE;
          end else begin
            mdc_o <= 1'b0;
            mdio_o <= shift_q[62];  // R22
            mdio_oe_o <= drive_next_w;
            shift_q <= {shift_q[62:0], 1'b0};
            bit_q <= bit_q + 6'd1;
            cnt_q <= half_w - 7'd1;
            state_q <= MS_LOW;
          end
        end
        default: state_q <= MS_IDLE;
      endcase
    end
  end

  // Phase length monitor for the clock checks
  logic mdc_prev_q;
  logic [7:0] ph_len_q;
  // Starts saturated so the long idle low phase never looks short
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mdc_prev_q <= 1'b0;
      ph_len_q <= 8'hFF;
    end else begin
      mdc_prev_q <= mdc_o;
      ph_len_q <= (mdc_o != mdc_prev_q) ? 8'h01 : ((ph_len_q == 8'hFF) ? ph_len_q : ph_len_q + 8'h01);
    end
  end

  a_mdc_idle_low: assert property (@(posedge clk_i) disable iff (rst_i)  // R2
    (state_q == MS_IDLE) |-> !mdc_o) else $error("Clock not low in idle");
  a_mdc_phase_min: assert property (@(posedge clk_i) disable iff (rst_i)  // R3
    (mdc_o != mdc_prev_q) && $past(!rst_i, 2) |-> ph_len_q >= 8'(MDC_HALF_MIN))
    else $error("Clock phase too short");
  a_preamble_ones: assert property (@(posedge clk_i) disable iff (rst_i)  // R4
    (state_q != MS_IDLE) && (bit_q < PRE_BITS) |-> mdio_o && mdio_oe_o)
    else $error("Preamble bit not one");
  a_start_zero: assert property (@(posedge clk_i) disable iff (rst_i)  // R5
    (state_q != MS_IDLE) && (bit_q == PRE_BITS) |-> !mdio_o) else $error("Start bit wrong");
  a_read_ta_release: assert property (@(posedge clk_i) disable iff (rst_i)  // R8
    (state_q != MS_IDLE) && !wr_q && (bit_q >= TA_POS) |-> !mdio_oe_o)
    else $error("Line driven in read turnaround");
  a_write_ta_one: assert property (@(posedge clk_i) disable iff (rst_i)  // R9
    (state_q != MS_IDLE) && wr_q && (bit_q == TA_POS) |-> mdio_o && mdio_oe_o)
    else $error("Write turnaround not one");
  a_data_on_fall: assert property (@(posedge clk_i) disable iff (rst_i)  // R22
    $changed(mdio_o) |-> !mdc_o) else $error("Data changed while clock high");
endmodule : station_mgmt_master
`default_nettype wire

/* File: design/phy_mgmt_and_mii_port.sv */
// Our own choices: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// Operation
// [R1] One PHY of 32, one register per frame
// [R2] Management clock low while idle
// [R3] Clock at most 2.5MHz, phases 160ns
// [R4] Frame opens with 32 one bits
// [R5] Start pattern 01 follows preamble
// [R6] Five bit PHY address, MSB first
// [R7] Five bit register address, MSB first
// [R8] Read turnaround: device releases both bits
// [R9] Write turnaround driven as 10
// [R10] Sixteen data bits, bit 15 first
// [R11] Idle line released, PHY pulls high
// [R12] Range code selects clock divisor
// [R13] Busy plus write sends write, clears busy
// [R14] Busy alone reads, loads data, clears busy
// [R15] Software leaves address and data alone
// [R16] Transmit enable marks valid nibbles
// [R17] Receive codes decoded into line classes
// [R18] Reduced mode uses two bit paths
// [R19] Software picks interface mode before traffic
// [R20] Collision handling only in half duplex
// [R21] Operation code 01 write, 10 read
// [R22] Drive after falling, sample on rising
module phy_mgmt_and_mii_port (
  input wire logic clk_i,                 // System clock, 250 MHz
  input wire logic rst_i,                 // Synchronous reset, active high
  input wire logic ce_i,                  // Clock enable, freezes state when low
  input wire logic wb_cyc_i,              // Bus cycle
  input wire logic wb_stb_i,              // Bus strobe
  input wire logic wb_we_i,               // Bus write
  input wire logic [7:0] wb_adr_i,        // Bus byte address
  input wire logic [3:0] wb_sel_i,        // Bus byte enables
  input wire logic [31:0] wb_dat_i,       // Bus write data
  output logic [31:0] wb_dat_o,           // Bus read data
  output logic wb_ack_o,                  // Bus acknowledge
  output logic mdc_o,                     // Management clock
  input wire logic mdio_i,                // Management data line level
  output logic mdio_o,                    // Management data drive value
  output logic mdio_oe_o,                 // Management data drive enable
  input wire logic tx_valid_i,            // Nibble offered by the MAC
  input wire logic [3:0] tx_nibble_i,     // Nibble to send
  output logic tx_ready_o,                // Nibble taken this cycle
  output logic mii_tx_en_o,               // Transmit enable pin
  output logic [3:0] mii_txd_o,           // Transmit data pins
  input wire logic mii_rx_dv_i,           // Receive valid, carrier+valid in reduced mode
  input wire logic mii_rx_er_i,           // Receive error pin
  input wire logic [3:0] mii_rxd_i,       // Receive data pins
  input wire logic mii_crs_i,             // Carrier sense pin
  input wire logic mii_col_i,             // Collision pin
  output logic rx_valid_o,                // Received nibble pulse
  output logic [3:0] rx_nibble_o,         // Received nibble
  output logic [2:0] rx_class_o,          // Line class of last sample
  output logic collision_o                // Collision seen in half duplex
);
  import eth_phy_pkg::*;

  localparam int NPIN = 9;

  mgmt_if mif ();

  logic [15:0] maddr_q;
  logic [15:0] mdata_q;
  logic [1:0] lcfg_q;
  logic [2:0] lstat_q;
  logic start_q;
  logic [NPIN-1:0] s1_q;
  logic [NPIN-1:0] s2_q;
  logic [NPIN-1:0] s3_q;
  logic [NPIN-1:0] pin_q;
  logic tx_half_q;
  logic [1:0] tx_hold_q;
  logic rx_half_q;
  logic [1:0] rx_lo_q;

  // Pin synchronisers: a change counts once stages two and three agree
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      // Data line idles high, so its stages start high to avoid a false edge
      s1_q <= {1'b1, 8'h00};
      s2_q <= {1'b1, 8'h00};
      s3_q <= {1'b1, 8'h00};
      pin_q <= {1'b1, 8'h00};
    end else if (ce_i) begin
      s1_q <= {mdio_i, mii_col_i, mii_crs_i, mii_rx_er_i, mii_rx_dv_i, mii_rxd_i};
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int i = 0; i < NPIN; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          pin_q[i] <= s3_q[i];
        end
      end
    end
  end

  // Filtered pin levels
  logic [3:0] rxd_w;
  logic rx_dv_w;
  logic rx_er_w;
  logic crs_w;
  logic col_w;
  logic mdio_in_w;
  assign rxd_w = pin_q[3:0];
  assign rx_dv_w = pin_q[4];
  assign rx_er_w = pin_q[5];
  assign crs_w = pin_q[6];
  assign col_w = pin_q[7];
  assign mdio_in_w = pin_q[8];

  // Bus decode; unmapped offsets read zero and still get an answer
  logic req_w;
  logic wr_w;
  logic hit_addr_w;
  logic hit_data_w;
  logic hit_cfg_w;
  logic hit_stat_w;
  logic [15:0] lane_mask_w;
  assign req_w = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_w = req_w && wb_we_i;
  assign hit_addr_w = (wb_adr_i == REG_MGMT_ADDR);
  assign hit_data_w = (wb_adr_i == REG_MGMT_DATA);
  assign hit_cfg_w = (wb_adr_i == REG_LINK_CFG);
  assign hit_stat_w = (wb_adr_i == REG_LINK_STAT);
  assign lane_mask_w = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // Read mux
  logic [31:0] rd_mux_w;
  assign rd_mux_w = hit_addr_w ? {16'h0000, maddr_q} :
                    hit_data_w ? {16'h0000, mdata_q} :
                    hit_cfg_w ? {30'h0, lcfg_q} :
                    hit_stat_w ? {28'h0, crs_w, lstat_q} : 32'h0000_0000;

  // Address and data are locked while busy, so a stray write cannot
  // corrupt a frame already on the wire
  logic busy_w;
  logic addr_wr_w;
  logic data_wr_w;
  logic [15:0] addr_new_w;
  logic go_w;
  assign busy_w = maddr_q[MA_BUSY];
  assign addr_wr_w = wr_w && hit_addr_w && !busy_w;  // R15
  assign data_wr_w = wr_w && hit_data_w && !busy_w;  // R15
  assign addr_new_w = (maddr_q & ~lane_mask_w) | (wb_dat_i[15:0] & lane_mask_w);
  assign go_w = addr_wr_w && addr_new_w[MA_BUSY];

  // Bus answer: one wait state, ack for one cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else if (ce_i) begin
      wb_ack_o <= req_w;
      if (req_w && !wb_we_i) begin
        wb_dat_o <= rd_mux_w;
      end
    end
  end

  // Management registers; a finished frame clears busy, a read loads data
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      maddr_q <= MGMT_ADDR_RST;
      mdata_q <= MGMT_DATA_RST;
      start_q <= 1'b0;
    end else if (ce_i) begin
      start_q <= go_w;
      if (addr_wr_w) begin
        maddr_q <= addr_new_w;
      end else if (mif.done) begin
        maddr_q[MA_BUSY] <= 1'b0;  // R13 R14
      end
      if (data_wr_w) begin
        mdata_q <= (mdata_q & ~lane_mask_w) | (wb_dat_i[15:0] & lane_mask_w);
      end else if (mif.done && !maddr_q[MA_WRITE]) begin
        mdata_q <= mif.rdata;  // R14
      end
    end
  end

  // Command to the serial engine; fields stay stable while busy
  assign mif.start = start_q;  // R1
  assign mif.wr = maddr_q[MA_WRITE];  // R13
  assign mif.range = maddr_q[MA_RANGE +: 3];  // R12
  assign mif.phy = maddr_q[MA_PHY +: 5];  // R6
  assign mif.reg_a = maddr_q[MA_REG +: 5];  // R7
  assign mif.wdata = mdata_q;  // R10

  station_mgmt_master u_mgmt (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .cmd(mif),
    .mdio_in_i(mdio_in_w),
    .mdc_o(mdc_o),
    .mdio_o(mdio_o),
    .mdio_oe_o(mdio_oe_o)
  );

  // Link configuration: interface mode and duplex. Changing the mode
  // mid-frame is not guarded; software sets it before traffic
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lcfg_q <= LINK_CFG_RST;
    end else if (ce_i && wr_w && hit_cfg_w && wb_sel_i[0]) begin
      lcfg_q <= wb_dat_i[1:0];  // R19
    end
  end

  logic rmii_w;
  logic fdx_w;
  assign rmii_w = lcfg_q[LC_RMII];
  assign fdx_w = lcfg_q[LC_FDX];

  // Transmit: whole nibbles, or two dibits low pair first in reduced mode
  logic tx_take_w;
  logic tx_half_d;
  assign tx_take_w = tx_valid_i && tx_ready_o;
  assign tx_half_d = rmii_w && !tx_half_q && tx_take_w;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mii_tx_en_o <= 1'b0;
      mii_txd_o <= 4'h0;
      tx_half_q <= 1'b0;
      tx_hold_q <= 2'h0;
      tx_ready_o <= 1'b1;
    end else if (ce_i) begin
      tx_half_q <= tx_half_d;
      tx_ready_o <= !tx_half_d;
      if (rmii_w && tx_half_q) begin
        mii_txd_o <= {2'h0, tx_hold_q};  // R18
      end else if (tx_take_w) begin
        mii_tx_en_o <= 1'b1;  // R16
        mii_txd_o <= rmii_w ? {2'h0, tx_nibble_i[1:0]} : tx_nibble_i;  // R16 R18
        tx_hold_q <= tx_nibble_i[3:2];
      end else begin
        mii_tx_en_o <= 1'b0;
        mii_txd_o <= 4'h0;  // Interframe content
      end
    end
  end

  // Receive line class
  logic [2:0] rx_class_d;
  assign rx_class_d = rx_dv_w ? (rx_er_w ? RXC_DATA_ERR : RXC_DATA) :  // R17
                      !rx_er_w ? RXC_IDLE :
                      (rxd_w == 4'h0) ? RXC_IDLE :
                      (rxd_w == 4'hE) ? RXC_FALSE_CAR : RXC_RESERVED;

  // Collision counts only in half duplex while sending
  logic coll_w;
  assign coll_w = !fdx_w && col_w && crs_w && mii_tx_en_o;  // R20

  // Receive data: reduced mode pairs two dibits, low pair first
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_valid_o <= 1'b0;
      rx_nibble_o <= 4'h0;
      rx_class_o <= RXC_IDLE;
      rx_half_q <= 1'b0;
      rx_lo_q <= 2'h0;
      collision_o <= 1'b0;
    end else if (ce_i) begin
      rx_class_o <= rx_class_d;
      collision_o <= coll_w;
      rx_valid_o <= 1'b0;
      if (!rx_dv_w) begin
        rx_half_q <= 1'b0;
      end else if (!rmii_w) begin
        rx_valid_o <= 1'b1;
        rx_nibble_o <= rxd_w;
      end else if (!rx_half_q) begin
        rx_half_q <= 1'b1;  // R18
        rx_lo_q <= rxd_w[1:0];
      end else begin
        rx_half_q <= 1'b0;
        rx_valid_o <= 1'b1;
        rx_nibble_o <= {rxd_w[1:0], rx_lo_q};  // R18
      end
    end
  end

  // Sticky status, write one to clear; a new event wins over the clear
  logic [2:0] stat_ev_w;
  logic [2:0] stat_clr_w;
  assign stat_ev_w = {coll_w, rx_class_d == RXC_DATA_ERR, rx_class_d == RXC_FALSE_CAR};
  assign stat_clr_w = (wr_w && hit_stat_w && wb_sel_i[0]) ? wb_dat_i[2:0] : 3'h0;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lstat_q <= 3'h0;
    end else if (ce_i) begin
      lstat_q <= (lstat_q & ~stat_clr_w) | stat_ev_w;  // R17 R20
    end
  end

  a_busy_clears: assert property (@(posedge clk_i) disable iff (rst_i)  // R13
    ce_i && mif.done |=> !maddr_q[MA_BUSY]) else $error("Busy not cleared after frame");
  a_read_loads_data: assert property (@(posedge clk_i) disable iff (rst_i)  // R14
    ce_i && mif.done && !maddr_q[MA_WRITE] |=> mdata_q == $past(mif.rdata))
    else $error("Read data not loaded");
  a_locked_while_busy: assert property (@(posedge clk_i) disable iff (rst_i)  // R15
    ce_i && busy_w && !mif.done |=> $stable(mdata_q) && $stable(maddr_q[15:1]))
    else $error("Registers changed during frame");
  a_tx_nibble_out: assert property (@(posedge clk_i) disable iff (rst_i)  // R16
    ce_i && !rmii_w && tx_valid_i |=> mii_tx_en_o && (mii_txd_o == $past(tx_nibble_i)))
    else $error("Nibble not sent");
  a_false_carrier: assert property (@(posedge clk_i) disable iff (rst_i)  // R17
    ce_i && !rx_dv_w && rx_er_w && (rxd_w == 4'hE) |=> rx_class_o == RXC_FALSE_CAR)
    else $error("False carrier not flagged");
  a_rmii_second_dibit: assert property (@(posedge clk_i) disable iff (rst_i)  // R18
    ce_i && rmii_w && tx_valid_i && tx_ready_o ##1 ce_i && rmii_w |=>
    mii_txd_o == {2'h0, $past(tx_nibble_i[3:2], 2)}) else $error("Dibit order wrong");
  a_fdx_no_coll: assert property (@(posedge clk_i) disable iff (rst_i)  // R20
    ce_i && fdx_w |=> !collision_o) else $error("Collision flagged in full duplex");
endmodule : phy_mgmt_and_mii_port
`default_nettype wire

/* File: test/phy_mgmt_model.sv */
`timescale 1ns/1ps
`default_nettype none
module phy_mgmt_model (
  input wire logic mdc_i,           // Management clock from the device
  input wire logic line_i,          // Resolved data line level
  input wire logic dev_oe_i,        // Device drive enable, seen for turnaround
  output logic drive_o,             // Our drive value
  output logic oe_o,                // Our drive enable
  output logic [5:0] pre_o,         // Ones counted before the start bit
  output logic [1:0] op_o,          // Captured operation
  output logic [4:0] phy_o,         // Captured PHY address
  output logic [4:0] reg_o,         // Captured register address
  output logic [1:0] ta_o,          // Turnaround levels
  output logic [1:0] ta_oe_o,       // Device enable during turnaround
  output logic [15:0] wdata_o       // Last written word
);
  logic [15:0] mem [32];
  logic [31:0] sr;
  logic [5:0] ones = 6'h00;
  int idx = -1;
  initial oe_o = 1'b0;
  initial drive_o = 1'b1;
  // Sample on the rising edge; idle mdc gives no edges, so ones restart per frame
  always @(posedge mdc_i) begin
    if (idx < 0) begin
      if (line_i) ones = ones + 6'h01;
      else begin
        pre_o = ones;
        ones = 6'h00;
        idx = 1;
      end
    end else begin
      sr = {sr[30:0], line_i};
      if (idx == 14 || idx == 15) ta_o = {ta_o[0], line_i};
      if (idx == 14 || idx == 15) ta_oe_o = {ta_oe_o[0], dev_oe_i};
      if (idx == 13) {op_o, phy_o, reg_o} = sr[11:0];
      if (idx == 31 && op_o == 2'b01) wdata_o = sr[15:0];
      if (idx == 31 && op_o == 2'b01) mem[reg_o] = sr[15:0];
      idx = (idx == 31) ? -1 : idx + 1;
    end
  end
  // Drive only after a falling edge, so the device sees a settled level
  always @(negedge mdc_i) begin
    oe_o = (op_o == 2'b10) && (idx >= 15);
    drive_o = (idx == 15) ? 1'b0 : mem[reg_o][31 - idx];
  end
endmodule : phy_mgmt_model
`default_nettype wire

/* File: test/phy_mgmt_and_mii_port_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module phy_mgmt_and_mii_port_tb;
  import eth_phy_pkg::*;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, txv = 0, dv = 0, er = 0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0, txn = 4'h0, rxd = 4'h0, txd, rxn;
  logic [31:0] dat = 32'h0, rd, rdat;
  logic ack, mdc, mdo, moe, pdo, poe, line, txr, txen, rxv, coll;
  logic [2:0] cls;
  logic [5:0] pre;
  logic [1:0] op, ta, taoe;
  logic [4:0] pa, ra;
  logic [15:0] wd;
  logic [8:0] rx_tab [6] = '{{6'h05, RXC_IDLE}, {6'h10, RXC_IDLE}, {6'h1E, RXC_FALSE_CAR},
    {6'h13, RXC_RESERVED}, {6'h27, RXC_DATA}, {6'h37, RXC_DATA_ERR}};
  int n_mismatch = 0, n_compared = 0, hi_run = 0, hi_len = 0;
  always #2 clk_i = ~clk_i;
  // Pull-up holds the line high when nobody drives it
  assign line = moe ? mdo : (poe ? pdo : 1'b1);
  phy_mgmt_and_mii_port uut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .mdc_o(mdc), .mdio_i(line), .mdio_o(mdo),
    .mdio_oe_o(moe), .tx_valid_i(txv), .tx_nibble_i(txn), .tx_ready_o(txr),
    .mii_tx_en_o(txen), .mii_txd_o(txd), .mii_rx_dv_i(dv), .mii_rx_er_i(er),
    .mii_rxd_i(rxd), .mii_crs_i(1'b0), .mii_col_i(1'b0), .rx_valid_o(rxv),
    .rx_nibble_o(rxn), .rx_class_o(cls), .collision_o(coll));
  phy_mgmt_model pm (.mdc_i(mdc), .line_i(line), .dev_oe_i(moe), .drive_o(pdo), .oe_o(poe),
    .pre_o(pre), .op_o(op), .phy_o(pa), .reg_o(ra), .ta_o(ta), .ta_oe_o(taoe), .wdata_o(wd));
  // Length of the last high phase of the management clock
  always @(posedge clk_i) begin
    if (mdc === 1'b1) hi_run <= hi_run + 1;
    else begin
      if (hi_run != 0) hi_len <= hi_run;
      hi_run <= 0;
    end
  end
  task stop_test;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : stop_test
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask : chk
  // One classic cycle; the request stands until ack is sampled
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {cyc, stb, we, adr, dat, sel} <= {2'b11, w, a, d, 4'h3};
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    rd = rdat;
    {cyc, stb} <= 2'b00;
  endtask : wb
  task wait_idle;
    int k;
    k = 0;
    do begin
      wb(1'b0, REG_MGMT_ADDR, 32'h0);
      k++;
    end while (rd[MA_BUSY] !== 1'b0 && k < 20000);
  endtask : wait_idle
  // Busy write during the frame must be ignored, so the model still sees d
  task frame(input logic w, input logic [2:0] c, input logic [4:0] r, input logic [15:0] d);
    if (w) wb(1'b1, REG_MGMT_DATA, {16'h0, d});
    wb(1'b1, REG_MGMT_ADDR, {16'h0, 5'h13, r, 1'b0, c, w, 1'b1});
    wb(1'b1, REG_MGMT_DATA, 32'h0);
    wait_idle;
    chk(32'(pre), 32'd32, "preamble");
    chk(32'(op), 32'(w ? OP_WRITE : OP_READ), "operation");
    chk(32'(pa), 32'h13, "phy address");
    chk(32'(ra), 32'(r), "register address");
    chk(32'(ta), 32'(TA_WRITE), "turnaround");
    chk(32'(taoe), w ? 32'h3 : 32'h0, "turnaround drive");
    chk(32'({mdc, moe}), 32'h0, "idle pins");
    chk(32'(hi_len), (c == 3'd4) ? 32'd51 : 32'd50, "clock phase");
    if (w) chk(32'(wd), 32'(d), "write data");
  endtask : frame
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, REG_MGMT_ADDR, 32'h0);
    chk(rd, 32'(MGMT_ADDR_RST), "address reset");
    wb(1'b0, REG_MGMT_DATA, 32'h0);
    chk(rd, 32'(MGMT_DATA_RST), "data reset");
    wb(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h0, "unmapped read");
    $display("test registers done");
    for (int c = 0; c < 5; c++) frame(1'b1, 3'(c), 5'(c + 10), 16'hC3A5 ^ 16'(c));
    $display("test writes done");
    frame(1'b0, 3'd0, 5'd12, 16'h0);
    wb(1'b0, REG_MGMT_DATA, 32'h0);
    chk(rd, 32'h0000C3A7, "read data");
    $display("test read done");
    @(posedge clk_i);
    {txv, txn} <= 5'h1A;
    @(posedge clk_i);
    txv <= 1'b0;
    #1 chk(32'({txen, txd}), 32'h1A, "transmit nibble");
    @(posedge clk_i);
    #1 chk(32'(txen), 32'h0, "transmit idle");
    $display("test transmit done");
    // Pins pass a synchroniser, so each code gets settling time
    for (int i = 0; i < 6; i++) begin
      @(posedge clk_i);
      {dv, er, rxd} <= rx_tab[i][8:3];
      repeat (8) @(posedge clk_i);
      #1 chk(32'(cls), 32'(rx_tab[i][2:0]), "receive class");
    end
    chk(32'({rxv, rxn}), 32'h17, "receive nibble");
    wb(1'b0, REG_LINK_STAT, 32'h0);
    chk(rd, 32'h3, "sticky status");
    wb(1'b1, REG_LINK_STAT, 32'h3);
    wb(1'b0, REG_LINK_STAT, 32'h0);
    chk(rd, 32'h2, "status set wins");
    $display("test receive done");
    wb(1'b1, REG_LINK_CFG, 32'h1);
    @(posedge clk_i);
    {txv, txn} <= 5'h19;
    @(posedge clk_i);
    txv <= 1'b0;
    #1 chk(32'({txr, txd}), 32'h01, "first dibit");
    @(posedge clk_i);
    #1 chk(32'({txr, txd}), 32'h12, "second dibit");
    $display("test reduced done");
    stop_test;
  end
  // Six frames of about 6400 cycles each, plus margin
  initial begin
    repeat (60000) @(posedge clk_i);
    n_mismatch++;
    stop_test;
  end
endmodule : phy_mgmt_and_mii_port_tb
`default_nettype wire
